//--- bench/fpcd_flash_model.sv
// behavioural flash device answering the protection command cycles
`timescale 1ns/1ps
`default_nettype none
module fpcd_flash_model
    import fpcd_pkg::*;
#(
    parameter logic [15:0] FILL_XOR = 16'h5A3C,
    parameter int ACC_NS = 90
)
(
    input wire logic [ADDR_W-1:0] flAddr,
    input wire logic [15:0] flDqOut,
    input wire logic flDqOe,
    input wire logic flCeN,
    input wire logic flWeN,
    input wire logic flOeN,
    output logic [15:0] flDqIn,
    output logic inOverlay = 1'b0,
    output int badCnt = 0,
    output int abortCnt = 0
);
    logic [15:0] mem [logic [ADDR_W-1:0]];
    logic [1023:0] lockBits = '1;
    logic [15:0] rdVal;
    logic [15:0] lastOut = 16'h0000;
    logic pendProg = 1'b0;
    logic pendExit = 1'b0;
    logic accDone = 1'b0;
    logic [1:0] unlk = 2'h0;
    logic [1:0] bufPh = 2'h0;
    logic [17:0] bufLine;
    int bufLeft;
    logic [7:0] cmd;
    logic weLow = 1'b0;
    logic ceFresh = 1'b0;
    // only a real low pulse of the write strobe counts, not the rise out of reset
    always @(negedge flWeN)
        weLow = 1'b1;
    // every read must start from a fresh chip enable fall
    always @(negedge flCeN)
        ceFresh = 1'b1;
    // commands land on the rising write strobe; upper byte and A11 up ignored
    always @(posedge flWeN)
    begin
        cmd = flDqOut[7:0];
        if (!weLow)
            cmd = 8'h00; // unknown to high at power-up, not a bus cycle
        else if (flCeN)
            badCnt++;
        else if (pendProg)
        begin
            if (inOverlay)
                lockBits[flAddr[25:16]] = flDqOut[0];
            else
                mem[flAddr] = flDqOut;
            pendProg = 1'b0;
        end
        else if (pendExit)
        begin
            inOverlay = (cmd == 8'h00) ? 1'b0 : inOverlay;
            pendExit = 1'b0;
        end
        else if (bufPh == 2'h1)
        begin
            bufLeft = int'(flDqOut) + 1;
            bufPh = 2'h2;
        end
        else if (bufPh == 2'h2)
        begin
            badCnt += (flAddr[25:8] != bufLine);
            mem[flAddr] = flDqOut;
            bufLeft--;
            bufPh = (bufLeft == 0) ? 2'h3 : 2'h2;
        end
        else if (bufPh == 2'h3)
        begin
            badCnt += (cmd != 8'h29);
            bufPh = 2'h0;
        end
        else if (unlk == 2'h2)
        begin
            unlk = 2'h0;
            if (cmd == 8'hE0 && flAddr[10:0] == 11'h555)
                inOverlay = 1'b1;
            else if (cmd == 8'hF0 && flAddr[10:0] == 11'h555)
                abortCnt++;
            else if (cmd == 8'h25)
                bufLine = flAddr[25:8];
            bufPh = (cmd == 8'h25) ? 2'h1 : 2'h0;
        end
        else if (cmd == 8'hF0)
            inOverlay = 1'b0;
        else if (cmd == 8'hAA && flAddr[10:0] == 11'h555)
            unlk = 2'h1;
        else if (unlk == 2'h1 && cmd == 8'h55 && flAddr[10:0] == 11'h2AA)
            unlk = 2'h2;
        else if (cmd == 8'hA0)
            pendProg = 1'b1;
        else if (cmd == 8'h90)
            pendExit = 1'b1;
        else
            unlk = 2'h0;
        weLow = 1'b0;
    end
    // lock status word in the overlay, array data otherwise
    always @(flCeN or flOeN or flAddr or inOverlay)
    begin
        if (inOverlay)
            rdVal = {15'h0000, lockBits[flAddr[25:16]]};
        else
            rdVal = mem.exists(flAddr) ? mem[flAddr] : (flAddr[15:0] ^ FILL_XOR);
    end
    // data only valid after the access time; read cycles never overlap writes
    always @(negedge flOeN)
    begin
        badCnt += (flDqOe || !flWeN || flCeN);
        badCnt += !ceFresh;
        ceFresh = 1'b0;
        accDone = 1'b0;
        #(ACC_NS) accDone = !flOeN;
    end
    always @(posedge flOeN)
    begin
        lastOut = rdVal;
        accDone = 1'b0;
    end
    // a released bus shows the inverse of the last word, never a held value
    assign flDqIn = (!flCeN && !flOeN && accDone) ? rdVal : ~lastOut;
endmodule : fpcd_flash_model
`default_nettype wire

//--- bench/fpcd_host_bench.sv
// self-checking bench for the flash protection command sequencer
`timescale 1ns/1ps
`default_nettype none
module fpcd_host_bench;
    import fpcd_pkg::*;
    localparam logic [15:0] FILL = 16'h5A3C;
    logic core_clk = 1'b0;
    logic reset_n = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h00000000;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h00000000;
    logic [31:0] hrdata, st, rd, d0, d1;
    logic hreadyout, hresp, flDqOe, flCeN, flWeN, flOeN, inOverlay;
    logic [ADDR_W-1:0] flAddr, a;
    logic [15:0] flDqOut, flDqIn;
    logic [9:0] sec;
    int badCnt, abortCnt, err_count = 0, checks_done = 0;
    always #2.5 core_clk = ~core_clk;
    fpcd_host dut (.core_clk(core_clk), .reset_n(reset_n), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .flAddr(flAddr), .flDqOut(flDqOut), .flDqIn(flDqIn), .flDqOe(flDqOe),
        .flCeN(flCeN), .flWeN(flWeN), .flOeN(flOeN));
    fpcd_flash_model #(.FILL_XOR(FILL)) flash (.flAddr(flAddr), .flDqOut(flDqOut),
        .flDqOe(flDqOe), .flCeN(flCeN), .flWeN(flWeN), .flOeN(flOeN), .flDqIn(flDqIn),
        .inOverlay(inOverlay), .badCnt(badCnt), .abortCnt(abortCnt));
    function automatic logic [15:0] expWord(input logic [25:0] adr);
        return adr[15:0] ^ FILL;
    endfunction : expWord
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        checks_done++;
        if (got !== exp)
        begin
            err_count++;
            $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk
    // one single word transfer, held until the slave's ready is seen
    task automatic ahb(input logic wr, input logic [7:0] adr, input logic [31:0] wd,
        output logic [31:0] rdat);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= {24'h000000, adr};
        hwrite <= wr;
        do @(posedge core_clk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        do @(posedge core_clk); while (hreadyout !== 1'b1);
        rdat = hrdata;
    endtask : ahb
    // first status read is thrown away; busy is already set by the edge that ends the control write
    task automatic opAt(input logic [25:0] adr, input logic [3:0] op, input logic [1:0] cnt);
        ahb(1'b1, REG_ADDR, {6'h00, adr}, rd);
        ahb(1'b1, REG_CTRL, {22'h000000, cnt, 4'h0, op}, rd);
        ahb(1'b0, REG_STAT, 32'h00000000, st);
        do ahb(1'b0, REG_STAT, 32'h00000000, st); while (st[STAT_BUSY] !== 1'b0);
    endtask : opAt
    task automatic finish_test();
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : finish_test
    // watchdog sized well above the whole sequence
    initial
    begin
        #200000;
        err_count++;
        finish_test();
    end
    initial
    begin
        void'($urandom(32'hCCCF));
        repeat (3) @(posedge core_clk);
        chk({flCeN, flWeN, flOeN, flDqOe, hresp}, 5'h1C, "idle strobes");
        reset_n <= 1'b1;
        ahb(1'b1, 8'h14, $urandom, rd);
        ahb(1'b0, 8'h14, 32'h00000000, rd);
        chk(rd, 32'h00000000, "unmapped");
        for (int i = 0; i < 4; i++)
        begin
            a = {1'b1, 25'($urandom)};
            opAt(a, 4'h7, 2'h0);
            chk(st[31:16], expWord(a), "array read");
        end
        opAt(a, 4'h1, 2'h0);
        chk(st[STAT_ERR], 1'b1, "set outside overlay");
        for (int op = 11; op < 16; op++)
        begin
            opAt(a, 4'(op), 2'h0);
            chk(st[STAT_ERR], 1'b1, "bad op");
        end
        opAt(a, 4'h0, 2'h0);
        chk({st[STAT_OVL], inOverlay, st[STAT_ERR]}, 3'h6, "enter");
        for (int i = 0; i < 3; i++)
        begin
            sec = 10'($urandom);
            opAt({sec, 16'($urandom)}, 4'h1, 2'h0);
            opAt({sec, 16'($urandom)}, 4'h3, 2'h0);
            chk(st[31:16], 32'h0, "protected");
            opAt({sec, 16'($urandom)}, 4'h2, 2'h0);
            opAt({sec, 16'($urandom)}, 4'h3, 2'h0);
            chk(st[31:16], 32'h1, "unprotected");
        end
        opAt({sec, 16'h0000}, 4'h1, 2'h0);
        opAt(a, 4'h7, 2'h0);
        chk(st[STAT_ERR], 1'b1, "array read in overlay");
        opAt(a, 4'h4, 2'h0);
        chk({st[STAT_OVL], inOverlay}, 2'h0, "exit");
        opAt(a, 4'h7, 2'h0);
        chk(st[31:16], expWord(a), "read after exit");
        opAt(a, 4'h0, 2'h0);
        opAt({sec, 16'hFFFF}, 4'h3, 2'h0);
        chk(st[31:16], 32'h0, "lock kept");
        opAt(a, 4'h5, 2'h0);
        chk({st[STAT_OVL], inOverlay}, 2'h0, "reset exit");
        d0 = $urandom;
        d1 = $urandom;
        ahb(1'b1, REG_DATA0, d0, rd);
        ahb(1'b1, REG_DATA1, d1, rd);
        opAt(26'h0000000, 4'h8, 2'h0);
        for (int j = 0; j < 4; j++)
        begin
            opAt(26'(j), 4'h7, 2'h0);
            chk(st[31:16], 16'({d1, d0} >> (16 * j)), "key word");
        end
        a = {1'b1, 17'($urandom), 8'hFE};
        opAt(a, 4'h9, 2'h3);
        for (int j = 0; j < 4; j++)
        begin
            opAt({a[25:8], 8'(a[7:0] + j)}, 4'h7, 2'h0);
            chk(st[31:16], 16'({d1, d0} >> (16 * j)), "buffer word");
        end
        opAt(26'h0000040, 4'hA, 2'h0);
        chk(st[STAT_TOUT], 1'b1, "timeout seen");
        opAt(a, 4'h7, 2'h0);
        chk(st[STAT_ERR], 1'b1, "read after timeout");
        opAt(a, 4'h5, 2'h0);
        opAt(a, 4'h7, 2'h0);
        chk({st[STAT_TOUT], st[STAT_ERR]}, 2'h0, "reset clears timeout");
        sec = 10'(abortCnt);
        opAt(a, 4'h6, 2'h0);
        chk(abortCnt, sec + 1, "abort reset");
        chk(badCnt, 0, "bus cycle shape");
        finish_test();
    end
endmodule : fpcd_host_bench
`default_nettype wire

//--- rtl/fpcd_host.sv
// host sequencer driving the flash protection command cycles from AHB-Lite
//
// Chosen here: the register addresses and the AHB-Lite register port.
`timescale 1ns/1ps
`default_nettype none
module fpcd_host
    import fpcd_pkg::*;
(
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    output logic [ADDR_W-1:0] flAddr,
    output logic [15:0] flDqOut,
    input wire logic [15:0] flDqIn,
    output logic flDqOe,
    output logic flCeN,
    output logic flWeN,
    output logic flOeN
);
    // one step of a command sequence: address, data, direction, end mark
    function automatic fpcd_step_t fpcdStep(input fpcd_op_t op, input logic [3:0] idx,
        input logic [1:0] cnt, input logic [ADDR_W-1:0] base, input logic [63:0] words);
        fpcd_step_t s;
        logic [1:0] j;
        s = '{last: 1'b0, isRead: 1'b0, addr: ADDR_ANY, data: D_EXIT2};
        j = 2'(idx >> 1);
        unique case (op)
            OP_ENTER, OP_ABORT, OP_BUF:
            begin
                if (idx == 4'h0)
                    s = '{1'b0, 1'b0, ADDR_UNLK1, D_UNLK1};
                else if (idx == 4'h1)
                    s = '{1'b0, 1'b0, ADDR_UNLK2, D_UNLK2};
                else if (op == OP_ENTER)
                    s = '{1'b1, 1'b0, ADDR_UNLK1, D_OVL_ENTER};
                else if (op == OP_ABORT)
                    s = '{1'b1, 1'b0, ADDR_UNLK1, D_RESET};
                else if (idx == 4'h2)
                    s = '{1'b0, 1'b0, base, D_BUF_LOAD};
                else if (idx == 4'h3)
                    s = '{1'b0, 1'b0, base, {14'h0000, cnt}};
                else if (idx <= 4'(cnt) + 4'h4)
                begin
                    j = 2'(idx - 4'h4);
                    // line bits kept, offset wraps inside the line
                    s.addr = {base[ADDR_W-1:LINE_LSB], base[LINE_LSB-1:0] + 8'(j)};
                    s.data = words[{j, 4'h0} +: 16];
                end
                else
                    s = '{1'b1, 1'b0, base, D_BUF_CONF};
            end
            OP_SET, OP_CLEAR:
            begin
                if (idx == 4'h0)
                    s.data = D_PROG;
                else
                    s = '{1'b1, 1'b0, base, (op == OP_SET) ? D_LOCK_SET : D_LOCK_CLR};
            end
            OP_STATUS, OP_READ, OP_POLL:
                s = '{1'b1, 1'b1, base, D_EXIT2};
            OP_EXIT:
            begin
                s.data = (idx == 4'h0) ? D_EXIT1 : D_EXIT2;
                s.last = (idx != 4'h0);
            end
            OP_RESET:
                s = '{1'b1, 1'b0, ADDR_ANY, D_RESET};
            OP_KEY:
            begin
                // one word per program command, word0 first
                if (idx[0] == 1'b0)
                    s.data = D_PROG;
                else
                    s = '{idx == 4'h7, 1'b0, ADDR_W'(j), words[{j, 4'h0} +: 16]};
            end
            default:
                s = '{1'b1, 1'b1, base, D_EXIT2};
        endcase
        return s;
    endfunction : fpcdStep

    logic wrPend_r;
    logic [7:0] wrAddr_r;
    logic [31:0] hrdata_r;
    fpcd_op_t op_r;
    logic [1:0] cnt_r;
    logic [ADDR_W-1:0] addr_r;
    logic [63:0] data_r;
    logic busy_r;
    logic ovl_r;
    logic tout_r;
    logic err_r;
    logic [15:0] rd_r;
    fpcd_bus_t st_r;
    logic [3:0] idx_r;
    logic [4:0] tmr_r;
    logic lastDone_r;
    logic ctrlWr;
    logic opOk;
    logic [3:0] reqOp;
    fpcd_step_t step;

    assign ctrlWr = wrPend_r && (wrAddr_r == REG_CTRL);
    assign reqOp = hwdata[3:0];
    assign step = fpcdStep(op_r, idx_r, cnt_r, addr_r, data_r);

    // legality of a requested operation against overlay and timeout state
    always_comb
    begin
        opOk = 1'b0;
        case (reqOp)
            OP_SET, OP_CLEAR, OP_STATUS: opOk = ovl_r;
            OP_READ: opOk = !ovl_r && !tout_r;
            OP_ENTER, OP_EXIT, OP_RESET, OP_ABORT, OP_KEY, OP_BUF, OP_POLL: opOk = 1'b1;
            default: opOk = 1'b0;
        endcase
    end

    // bus slave: zero wait states, hsize ignored since only words are used
    always_ff @(posedge core_clk)
    begin
        if (!reset_n)
        begin
            wrPend_r <= 1'b0;
            wrAddr_r <= 8'h00;
            hrdata_r <= 32'h00000000;
        end
        else
        begin
            wrPend_r <= hsel && hready && htrans[1] && hwrite;
            if (hsel && hready && htrans[1])
            begin
                wrAddr_r <= haddr[7:0];
                case (haddr[7:0])
                    REG_CTRL: hrdata_r <= {22'h000000, cnt_r, 4'h0, op_r};
                    REG_ADDR: hrdata_r <= 32'(addr_r);
                    REG_DATA0: hrdata_r <= data_r[31:0];
                    REG_DATA1: hrdata_r <= data_r[63:32];
                    REG_STAT: hrdata_r <= {rd_r, 12'h000, tout_r, err_r, ovl_r, busy_r};
                    default: hrdata_r <= 32'h00000000;
                endcase
            end
        end
    end

    // software registers; writes while busy are dropped to keep a sequence whole
    always_ff @(posedge core_clk)
    begin
        if (!reset_n)
        begin
            addr_r <= '0;
            data_r <= 64'h0000000000000000;
            op_r <= OP_RESET;
            cnt_r <= 2'b00;
        end
        else if (wrPend_r && !busy_r)
        begin
            if (wrAddr_r == REG_ADDR)
                addr_r <= hwdata[ADDR_W-1:0];
            if (wrAddr_r == REG_DATA0)
                data_r[31:0] <= hwdata;
            if (wrAddr_r == REG_DATA1)
                data_r[63:32] <= hwdata;
            if (ctrlWr && opOk)
            begin
                op_r <= fpcd_op_t'(reqOp);
                cnt_r <= hwdata[CTRL_CNT_LSB +: 2];
            end
        end
    end

    // overlay and timeout tracking; error sticks until the next accepted request
    always_ff @(posedge core_clk)
    begin
        if (!reset_n)
        begin
            ovl_r <= 1'b0;
            tout_r <= 1'b0;
            err_r <= 1'b0;
        end
        else
        begin
            if (ctrlWr && !busy_r)
            begin
                err_r <= !opOk;
                if (opOk && reqOp == OP_ENTER)
                    ovl_r <= 1'b1;
                if (opOk && (reqOp == OP_EXIT || reqOp == OP_RESET))
                begin
                    ovl_r <= 1'b0;
                    tout_r <= 1'b0;
                end
            end
            else if (ctrlWr)
                err_r <= 1'b1;
            // a status poll showing the timeout bit blocks array reads
            if (st_r == B_STROBE && tmr_r == 5'h00 && op_r == OP_POLL && flDqIn[TIMEOUT_BIT])
                tout_r <= 1'b1;
        end
    end

    // bus cycle engine: gap with CE high, setup, strobe, hold
    always_ff @(posedge core_clk)
    begin
        if (!reset_n)
        begin
            st_r <= B_IDLE;
            busy_r <= 1'b0;
            idx_r <= 4'h0;
            tmr_r <= 5'h00;
            lastDone_r <= 1'b0;
            rd_r <= 16'h0000;
            flAddr <= '0;
            flDqOut <= 16'h0000;
            flDqOe <= 1'b0;
            flCeN <= 1'b1;
            flWeN <= 1'b1;
            flOeN <= 1'b1;
        end
        else
        begin
            if (tmr_r != 5'h00)
                tmr_r <= tmr_r - 5'h01;
            unique case (st_r)
                B_IDLE:
                begin
                    if (ctrlWr && !busy_r && opOk)
                    begin
                        busy_r <= 1'b1;
                        idx_r <= 4'h0;
                        lastDone_r <= 1'b0;
                        tmr_r <= CEH_CYC - 5'h01;
                        st_r <= B_GAP;
                    end
                end
                B_GAP:
                begin
                    // CE stays high before every access, reads included
                    if (tmr_r == 5'h00 && lastDone_r)
                    begin
                        busy_r <= 1'b0;
                        st_r <= B_IDLE;
                    end
                    else if (tmr_r == 5'h00)
                    begin
                        flAddr <= step.addr;
                        flDqOut <= step.data;
                        flDqOe <= !step.isRead;
                        flCeN <= 1'b0;
                        tmr_r <= SETUP_CYC - 5'h01;
                        st_r <= B_SETUP;
                    end
                end
                B_SETUP:
                begin
                    if (tmr_r == 5'h00)
                    begin
                        flWeN <= step.isRead;
                        flOeN <= !step.isRead;
                        tmr_r <= (step.isRead ? ACC_CYC : WP_CYC) - 5'h01;
                        st_r <= B_STROBE;
                    end
                end
                B_STROBE:
                begin
                    if (tmr_r == 5'h00)
                    begin
                        if (step.isRead)
                            rd_r <= flDqIn;
                        flWeN <= 1'b1;
                        flOeN <= 1'b1;
                        tmr_r <= HOLD_CYC - 5'h01;
                        st_r <= B_HOLD;
                    end
                end
                B_HOLD:
                begin
                    if (tmr_r == 5'h00)
                    begin
                        flCeN <= 1'b1;
                        flDqOe <= 1'b0;
                        lastDone_r <= step.last;
                        if (!step.last)
                            idx_r <= idx_r + 4'h1;
                        tmr_r <= CEH_CYC - 5'h01;
                        st_r <= B_GAP;
                    end
                end
            endcase
        end
    end

    assign hrdata = hrdata_r;
    // zero wait states: the slave is always ready
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    chk_entry_cmd: assert property (@(posedge core_clk) disable iff (!reset_n)
        $fell(flWeN) && op_r == OP_ENTER |-> (idx_r == 4'h1) ? flAddr == ADDR_UNLK2
        : (flAddr == ADDR_UNLK1 && flDqOut == ((idx_r == 4'h0) ? D_UNLK1 : D_OVL_ENTER)))
        else $error("overlay entry cycle wrong");
    chk_lock_write: assert property (@(posedge core_clk) disable iff (!reset_n)
        $fell(flWeN) && (op_r == OP_SET || op_r == OP_CLEAR) && idx_r == 4'h1
        |-> flAddr[ADDR_W-1:SECT_LSB] == addr_r[ADDR_W-1:SECT_LSB]
        && flDqOut == ((op_r == OP_SET) ? D_LOCK_SET : D_LOCK_CLR))
        else $error("lock set or clear cycle wrong");
    chk_exit_first: assert property (@(posedge core_clk) disable iff (!reset_n)
        ctrlWr && !busy_r && reqOp == OP_READ && ovl_r |=> err_r && !busy_r)
        else $error("array read taken inside overlay");
    chk_buf_line: assert property (@(posedge core_clk) disable iff (!reset_n)
        $fell(flWeN) && op_r == OP_BUF && idx_r >= 4'h3 && !step.last
        |-> flAddr[ADDR_W-1:LINE_LSB] == addr_r[ADDR_W-1:LINE_LSB]
        && (idx_r != 4'h3 || flDqOut == {14'h0000, cnt_r}))
        else $error("buffer count or line wrong");
    chk_tout_block: assert property (@(posedge core_clk) disable iff (!reset_n)
        tout_r && !(ctrlWr && !busy_r && (reqOp == OP_RESET || reqOp == OP_EXIT))
        |=> tout_r)
        else $error("timeout flag dropped without reset");
    chk_abort_len: assert property (@(posedge core_clk) disable iff (!reset_n)
        $fell(busy_r) && op_r == OP_ABORT |-> $past(idx_r) == 4'h2)
        else $error("abort reset not three cycles");
    chk_key_order: assert property (@(posedge core_clk) disable iff (!reset_n)
        $fell(flWeN) && op_r == OP_KEY
        |-> idx_r[0] ? flAddr == ADDR_W'(idx_r >> 1) : flDqOut == D_PROG)
        else $error("key word order wrong");
    chk_read_acc: assert property (@(posedge core_clk) disable iff (!reset_n)
        $rose(flOeN) |-> $past(flOeN, ACC_CYC) == 1'b0 && !flCeN)
        else $error("read strobe shorter than access time");
    chk_read_ceh: assert property (@(posedge core_clk) disable iff (!reset_n)
        $fell(flCeN) |-> $past(flCeN, 2) && $past(flCeN, 3))
        else $error("chip enable not high before access");
endmodule : fpcd_host
`default_nettype wire

//--- rtl/fpcd_pkg.sv
// constants, types and helpers for the flash protection command sequencer
package fpcd_pkg;
    localparam int ADDR_W = 26;
    localparam int SECT_LSB = 16;
    localparam int LINE_LSB = 8;
    localparam logic [ADDR_W-1:0] ADDR_UNLK1 = 26'h0000555;
    localparam logic [ADDR_W-1:0] ADDR_UNLK2 = 26'h00002AA;
    localparam logic [ADDR_W-1:0] ADDR_ANY = 26'h0000000;
    localparam logic [15:0] D_UNLK1 = 16'h00AA;
    localparam logic [15:0] D_UNLK2 = 16'h0055;
    localparam logic [15:0] D_OVL_ENTER = 16'h00E0;
    localparam logic [15:0] D_PROG = 16'h00A0;
    localparam logic [15:0] D_EXIT1 = 16'h0090;
    localparam logic [15:0] D_EXIT2 = 16'h0000;
    localparam logic [15:0] D_RESET = 16'h00F0;
    localparam logic [15:0] D_BUF_LOAD = 16'h0025;
    localparam logic [15:0] D_BUF_CONF = 16'h0029;
    localparam logic [15:0] D_LOCK_SET = 16'h0000;
    localparam logic [15:0] D_LOCK_CLR = 16'h0001;
    localparam int TIMEOUT_BIT = 5;
    // register map, one aligned word each
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_ADDR = 8'h04;
    localparam logic [7:0] REG_DATA0 = 8'h08;
    localparam logic [7:0] REG_DATA1 = 8'h0C;
    localparam logic [7:0] REG_STAT = 8'h10;
    localparam int CTRL_CNT_LSB = 8;
    localparam int STAT_BUSY = 0;
    localparam int STAT_OVL = 1;
    localparam int STAT_ERR = 2;
    localparam int STAT_TOUT = 3;
    localparam int STAT_RD_LSB = 16;
    // bus timing in ns at a 5 ns clock
    localparam int CLK_NS = 5;
    localparam int T_SETUP_NS = 10;
    localparam int T_WP_NS = 35;
    localparam int RANDOM_ACCESS_TIME_NS = 100;
    localparam int T_HOLD_NS = 10;
    localparam int T_CEH_NS = 20;
    function automatic int nsToCyc(input int ns);
        return (ns + CLK_NS - 1) / CLK_NS;
    endfunction : nsToCyc
    localparam logic [4:0] SETUP_CYC = 5'(nsToCyc(T_SETUP_NS));
    localparam logic [4:0] WP_CYC = 5'(nsToCyc(T_WP_NS));
    localparam logic [4:0] ACC_CYC = 5'(nsToCyc(RANDOM_ACCESS_TIME_NS));
    localparam logic [4:0] HOLD_CYC = 5'(nsToCyc(T_HOLD_NS));
    localparam logic [4:0] CEH_CYC = 5'(nsToCyc(T_CEH_NS));
    typedef enum logic [3:0] {
        OP_ENTER = 4'h0, OP_SET = 4'h1, OP_CLEAR = 4'h2, OP_STATUS = 4'h3,
        OP_EXIT = 4'h4, OP_RESET = 4'h5, OP_ABORT = 4'h6, OP_READ = 4'h7,
        OP_KEY = 4'h8, OP_BUF = 4'h9, OP_POLL = 4'hA
    } fpcd_op_t;
    typedef enum logic [2:0] {
        B_IDLE = 3'b000, B_GAP = 3'b001, B_SETUP = 3'b011,
        B_STROBE = 3'b010, B_HOLD = 3'b110
    } fpcd_bus_t;
    typedef struct packed {
        logic last;
        logic isRead;
        logic [ADDR_W-1:0] addr;
        logic [15:0] data;
    } fpcd_step_t;
endpackage : fpcd_pkg
